// ---- design/tps_pkg.sv ----
package tps_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   // Arbitrary neutral value for the device type code
   localparam logic [5:0] DEV_TYPE_CODE = 6'h15;
   localparam int unsigned INTERNAL_WRITE_TIME_US = 10000;
   localparam int unsigned INTERNAL_WRITE_CYCLES =
      INTERNAL_WRITE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PAGE_BYTES = 8;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0][7:0] POT_ADDR = {8'hFA, 8'hF8, 8'hF9};
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_ASEL = 2;
   localparam int PIN_WP = 3;
   localparam logic [3:0] PIN_RESET = 4'hF;
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_RXACK, ST_TX, ST_TXACK
   } tps_state_t;
   typedef enum logic [1:0] {K_CTRL, K_ADDR, K_DATA} tps_kind_t;
endpackage

// ---- design/tps_nvm_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface tps_nvm_if;
   logic [7:0] addr;
   logic [7:0] rdData;
   logic bufWr;
   logic [7:0] bufData;
   logic commit;
   logic discard;
   logic wp;
   logic busy;
   logic [2:0][6:0] pots;
   modport ctl (
      output addr, bufWr, bufData, commit, discard, wp,
      input rdData, busy, pots
   );
   modport mem (
      input addr, bufWr, bufData, commit, discard, wp,
      output rdData, busy, pots
   );
endinterface
`default_nettype wire

// ---- design/tps_nvm.sv ----
`timescale 1ns/100ps
`default_nettype none
module tps_nvm #(
   parameter int unsigned WRITE_CYCLES = tps_pkg::INTERNAL_WRITE_CYCLES,
   parameter int unsigned PAGE_BYTES = tps_pkg::PAGE_BYTES
) (
   input wire logic clock,
   input wire logic sys_rst,
   tps_nvm_if.mem port
);
   localparam int PW = $clog2(PAGE_BYTES);
   localparam int TW = $clog2(WRITE_CYCLES + 1);
   logic [7:0] memQ [256];
   logic [7:0] bufQ [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] bufValQ;
   logic [7-PW:0] pageQ;
   logic [TW-1:0] timerQ;
   logic busyQ;
   logic [2:0][6:0] potQ;
   logic doWrite;

   function automatic logic isPot(input logic [7:0] a);
      return (a == tps_pkg::POT_ADDR[0]) || (a == tps_pkg::POT_ADDR[1])
         || (a == tps_pkg::POT_ADDR[2]);
   endfunction

   assign doWrite = port.commit && !busyQ && (|bufValQ);
   assign port.rdData = memQ[port.addr];
   assign port.busy = busyQ;
   assign port.pots = potQ;

   // ------------------------------------------------------------
   // Page buffer, filled per data byte, committed only by a stop
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         bufValQ <= '0;
         pageQ <= '0;
      end
      else if (port.discard || doWrite)
         bufValQ <= '0;
      else if (port.bufWr)
      begin
         bufQ[port.addr[PW-1:0]] <= port.bufData;
         bufValQ[port.addr[PW-1:0]] <= 1'b1;
         pageQ <= port.addr[7:PW];
      end
   end

   // ------------------------------------------------------------
   // Internally timed write
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         busyQ <= 1'b0;
         timerQ <= '0;
      end
      else if (doWrite)
      begin
         busyQ <= 1'b1;
         timerQ <= TW'(WRITE_CYCLES - 1);
      end
      else if (busyQ)
      begin
         if (timerQ == '0)
            busyQ <= 1'b0;
         else
            timerQ <= timerQ - 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         for (int i = 0; i < 256; i++)
            memQ[i] <= 8'h00;
      else if (doWrite)
         for (int i = 0; i < PAGE_BYTES; i++)
            if (bufValQ[i] && !(isPot({pageQ, PW'(i)}) && port.wp))
               memQ[{pageQ, PW'(i)}] <= isPot({pageQ, PW'(i)}) ?
                  {1'b0, bufQ[i][6:0]} : bufQ[i];
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         potQ <= '0;
      else
         for (int g = 0; g < 3; g++)
            potQ[g] <= memQ[tps_pkg::POT_ADDR[g]][6:0];
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_wp_lock: assert property (@(posedge clock) disable iff (sys_rst)
      (doWrite && port.wp) |=> ##1 (potQ == $past(potQ, 2)))
      else $error("pot position changed while write protected");
endmodule
`default_nettype wire

// ---- design/tps_slave.sv ----
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module tps_slave #(
   parameter logic [5:0] DEV_CODE = tps_pkg::DEV_TYPE_CODE,
   parameter int unsigned WRITE_CYCLES = tps_pkg::INTERNAL_WRITE_CYCLES,
   parameter int unsigned PAGE_BYTES = tps_pkg::PAGE_BYTES
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic addressSelectPin,
   input wire logic writeProtectPin,
   input wire logic [1:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   output logic [6:0] pot0Pos,
   output logic [6:0] pot1Pos,
   output logic [6:0] pot2Pos
);
   localparam int PW = $clog2(PAGE_BYTES);
   logic [3:0] pinRaw;
   logic [3:0] s1Q;
   logic [3:0] s2Q;
   logic [3:0] s3Q;
   logic [3:0] pinQ;
   logic sclPrevQ;
   logic sdaPrevQ;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   tps_pkg::tps_state_t stateQ;
   tps_pkg::tps_kind_t kindQ;
   logic [3:0] bitCntQ;
   logic [7:0] rxQ;
   logic [7:0] txQ;
   logic readQ;
   logic mackQ;
   logic sdaOeNQ;
   logic sdaOutQ;
   logic [7:0] cntQ;
   logic enQ;
   logic [15:0] regRdataQ;
   logic [2:0][6:0] potOutQ;
   logic byteEnd;
   logic ctrlEnd;
   logic ctrlMatch;
   logic loadTx;

   tps_nvm_if nvmIf ();

   tps_nvm #(
      .WRITE_CYCLES(WRITE_CYCLES),
      .PAGE_BYTES(PAGE_BYTES)
   ) uNvm (
      .clock(clock),
      .sys_rst(sys_rst),
      .port(nvmIf.mem)
   );

   // ------------------------------------------------------------
   // Pin synchronisers and bus conditions
   // ------------------------------------------------------------
   assign pinRaw = {writeProtectPin, addressSelectPin, sdaIn, sclIn};

   for (genvar g = 0; g < 4; g++)
   begin : gSync
      // Three stages and agreement filter; short at 400 kHz SCL
      always_ff @(posedge clock)
      begin
         if (sys_rst)
         begin
            s1Q[g] <= tps_pkg::PIN_RESET[g];
            s2Q[g] <= tps_pkg::PIN_RESET[g];
            s3Q[g] <= tps_pkg::PIN_RESET[g];
            pinQ[g] <= tps_pkg::PIN_RESET[g];
         end
         else
         begin
            s1Q[g] <= pinRaw[g];
            s2Q[g] <= s1Q[g];
            s3Q[g] <= s2Q[g];
            if (s2Q[g] == s3Q[g])
               pinQ[g] <= s3Q[g];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         sclPrevQ <= 1'b1;
         sdaPrevQ <= 1'b1;
      end
      else
      begin
         sclPrevQ <= pinQ[tps_pkg::PIN_SCL];
         sdaPrevQ <= pinQ[tps_pkg::PIN_SDA];
      end
   end

   assign sclRise = pinQ[tps_pkg::PIN_SCL] && !sclPrevQ;
   assign sclFall = !pinQ[tps_pkg::PIN_SCL] && sclPrevQ;
   // SDA edges with SCL high are conditions, not data
   assign startEv = pinQ[tps_pkg::PIN_SCL] && sclPrevQ && sdaPrevQ
      && !pinQ[tps_pkg::PIN_SDA];
   assign stopEv = pinQ[tps_pkg::PIN_SCL] && sclPrevQ && !sdaPrevQ
      && pinQ[tps_pkg::PIN_SDA];

   assign byteEnd = (stateQ == tps_pkg::ST_RX) && sclFall
      && (bitCntQ == tps_pkg::BYTE_BITS);
   assign ctrlEnd = byteEnd && (kindQ == tps_pkg::K_CTRL);
   assign ctrlMatch = (rxQ[7:2] == DEV_CODE)
      && (rxQ[1] == pinQ[tps_pkg::PIN_ASEL])
      && enQ && !nvmIf.busy;
   assign loadTx = sclFall && !startEv && !stopEv
      && (((stateQ == tps_pkg::ST_RXACK) && readQ
      && (kindQ == tps_pkg::K_CTRL))
      || ((stateQ == tps_pkg::ST_TXACK) && mackQ));

   // ------------------------------------------------------------
   // Byte engine
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         stateQ <= tps_pkg::ST_IDLE;
         kindQ <= tps_pkg::K_CTRL;
         bitCntQ <= 4'h0;
         rxQ <= 8'h00;
         txQ <= 8'h00;
         readQ <= 1'b0;
         mackQ <= 1'b0;
         sdaOeNQ <= 1'b1;
      end
      else if (stopEv)
      begin
         stateQ <= tps_pkg::ST_IDLE;
         sdaOeNQ <= 1'b1;
      end
      else if (startEv)
      begin
         stateQ <= tps_pkg::ST_RX;
         kindQ <= tps_pkg::K_CTRL;
         bitCntQ <= 4'h0;
         sdaOeNQ <= 1'b1;
      end
      else
      begin
         case (stateQ)
            tps_pkg::ST_RX:
               if (sclRise)
               begin
                  rxQ <= {rxQ[6:0], pinQ[tps_pkg::PIN_SDA]};
                  bitCntQ <= bitCntQ + 4'h1;
               end
               else if (byteEnd)
               begin
                  if (kindQ != tps_pkg::K_CTRL || ctrlMatch)
                  begin
                     stateQ <= tps_pkg::ST_RXACK;
                     sdaOeNQ <= 1'b0;
                  end
                  else
                     stateQ <= tps_pkg::ST_IDLE;
                  if (kindQ == tps_pkg::K_CTRL)
                     readQ <= rxQ[0];
               end
            tps_pkg::ST_RXACK:
               if (sclFall)
               begin
                  bitCntQ <= 4'h0;
                  if (readQ && kindQ == tps_pkg::K_CTRL)
                  begin
                     stateQ <= tps_pkg::ST_TX;
                     txQ <= nvmIf.rdData;
                     sdaOeNQ <= nvmIf.rdData[7];
                  end
                  else
                  begin
                     stateQ <= tps_pkg::ST_RX;
                     kindQ <= (kindQ == tps_pkg::K_CTRL) ?
                        tps_pkg::K_ADDR : tps_pkg::K_DATA;
                     sdaOeNQ <= 1'b1;
                  end
               end
            tps_pkg::ST_TX:
               if (sclFall)
               begin
                  bitCntQ <= bitCntQ + 4'h1;
                  if (bitCntQ + 4'h1 == tps_pkg::BYTE_BITS)
                  begin
                     stateQ <= tps_pkg::ST_TXACK;
                     sdaOeNQ <= 1'b1;
                  end
                  else
                  begin
                     txQ <= {txQ[6:0], 1'b0};
                     sdaOeNQ <= txQ[6];
                  end
               end
            tps_pkg::ST_TXACK:
               if (sclRise)
                  mackQ <= !pinQ[tps_pkg::PIN_SDA];
               else if (sclFall)
               begin
                  bitCntQ <= 4'h0;
                  if (mackQ)
                  begin
                     stateQ <= tps_pkg::ST_TX;
                     txQ <= nvmIf.rdData;
                     sdaOeNQ <= nvmIf.rdData[7];
                  end
                  else
                  begin
                     stateQ <= tps_pkg::ST_IDLE;
                     sdaOeNQ <= 1'b1;
                  end
               end
            default:
               stateQ <= tps_pkg::ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Address counter
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         cntQ <= tps_pkg::ADDR_RESET;
      else if (loadTx)
         cntQ <= cntQ + 8'h01;
      else if (byteEnd && kindQ == tps_pkg::K_ADDR)
         cntQ <= rxQ;
      else if (byteEnd && kindQ == tps_pkg::K_DATA)
         cntQ <= {cntQ[7:PW], cntQ[PW-1:0] + PW'(1)};
   end

   assign nvmIf.addr = cntQ;
   assign nvmIf.bufWr = byteEnd && (kindQ == tps_pkg::K_DATA);
   assign nvmIf.bufData = rxQ;
   assign nvmIf.commit = stopEv;
   assign nvmIf.discard = startEv;
   assign nvmIf.wp = pinQ[tps_pkg::PIN_WP];

   // ------------------------------------------------------------
   // Register port and outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         enQ <= tps_pkg::CTRL_ENABLE_RESET;
      else if (regWr && regAddr == tps_pkg::REG_CTRL)
         enQ <= regWdata[0];
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst || !regRd)
         regRdataQ <= 16'h0000;
      else if (regAddr == tps_pkg::REG_CTRL)
         regRdataQ <= {15'h0000, enQ};
      else if (regAddr == tps_pkg::REG_STATUS)
         regRdataQ <= {cntQ, 5'h00, pinQ[tps_pkg::PIN_WP],
            stateQ != tps_pkg::ST_IDLE, nvmIf.busy};
      else
         regRdataQ <= 16'h0000;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         potOutQ <= '0;
         sdaOutQ <= 1'b0;
      end
      else
      begin
         potOutQ <= nvmIf.pots;
         sdaOutQ <= 1'b0;
      end
   end

   assign sdaOut = sdaOutQ;
   assign sdaOeN = sdaOeNQ;
   assign regRdata = regRdataQ;
   assign pot0Pos = potOutQ[0];
   assign pot1Pos = potOutQ[1];
   assign pot2Pos = potOutQ[2];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_busy_no_ack: assert property (ctrlEnd && nvmIf.busy
      && !stopEv |=> ((stateQ == tps_pkg::ST_IDLE) && sdaOeNQ) [*2])
      else $error("control byte acknowledged during internal write");
   a_ctrl_mismatch: assert property (ctrlEnd
      && !ctrlMatch && !stopEv |=> stateQ == tps_pkg::ST_IDLE && sdaOeNQ)
      else $error("mismatching control byte not ignored");
   a_read_mode: assert property (ctrlEnd && ctrlMatch
      && rxQ[0] |=> readQ && !sdaOeNQ && stateQ == tps_pkg::ST_RXACK)
      else $error("read control byte did not enter read mode");
   a_cnt_step: assert property (loadTx
      |=> cntQ == $past(cntQ) + 8'h01)
      else $error("address counter did not step after byte load");
   a_tx_msb: assert property (loadTx
      |=> sdaOeNQ == $past(nvmIf.rdData[7]))
      else $error("first bit sent is not the counter byte MSB");
   a_ack_hold: assert property (stateQ == tps_pkg::ST_RXACK
      && pinQ[tps_pkg::PIN_SCL] |-> !sdaOeNQ)
      else $error("acknowledge released during clock high");
   a_nack_release: assert property (stateQ == tps_pkg::ST_TXACK
      && sclFall && !mackQ && !startEv && !stopEv
      |=> stateQ == tps_pkg::ST_IDLE && sdaOeNQ)
      else $error("SDA not released after master nack");
   a_sda_stable: assert property (stateQ == tps_pkg::ST_TX
      && pinQ[tps_pkg::PIN_SCL] && sclPrevQ |=> $stable(sdaOeNQ))
      else $error("SDA changed while SCL high");
   a_start_restart: assert property (startEv && !stopEv
      |=> stateQ == tps_pkg::ST_RX && kindQ == tps_pkg::K_CTRL
      && bitCntQ == 4'h0)
      else $error("start did not restart control byte reception");
   a_page_wrap: assert property (byteEnd && kindQ == tps_pkg::K_DATA
      && !stopEv |=> cntQ[7:PW] == $past(cntQ[7:PW]))
      else $error("page write left its page");

   c_seq_read: cover property (loadTx && stateQ == tps_pkg::ST_TXACK);
   c_busy_poll: cover property (ctrlEnd && nvmIf.busy);
   c_write_stop: cover property (stopEv && kindQ == tps_pkg::K_DATA
      && !readQ);
   c_random_read: cover property (startEv
      && kindQ == tps_pkg::K_DATA ##[1:1000] loadTx);
endmodule
`default_nettype wire

// ---- verification/tps_bus_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module tps_bus_master (
   input wire logic clock,
   input wire logic sdaWire,
   output logic sclOut,
   output logic sdaLow
);
   int halfP = 25;
   initial
   begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // ----------------------------------------
   // One bit: data moves only while SCL is low
   // ----------------------------------------
   task automatic bitIo(input logic b, output logic s);
      tick(2);
      sdaLow <= ~b;
      tick(halfP);
      sclOut <= 1'b1;
      tick(2);
      s = sdaWire;
      tick(halfP - 2);
      // A level that is not held through the high phase reads as 1
      s = s | sdaWire;
      sclOut <= 1'b0;
   endtask
   task automatic start();
      tick(2);
      sdaLow <= 1'b0;
      tick(halfP);
      sclOut <= 1'b1;
      tick(halfP);
      sdaLow <= 1'b1;
      tick(halfP);
      sclOut <= 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sdaLow <= 1'b1;
      tick(halfP);
      sclOut <= 1'b1;
      tick(halfP);
      sdaLow <= 1'b0;
      tick(halfP);
   endtask
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitIo(d[i], s);
      end
      bitIo(1'b1, s);
      ack = ~s;
   endtask
   task automatic rdByte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitIo(1'b1, s);
         d[i] = s;
      end
      bitIo(~more, s);
   endtask
endmodule
`default_nettype wire

// ---- verification/test_two_wire_pot_slave_read_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_two_wire_pot_slave_read_port;
   localparam int WC = 1000;
   logic clock = 1'b0;
   logic sysRst = 1'b1;
   logic sclOut, sdaLow, sdaOut, sdaOeN, sdaWire;
   logic asel = 1'b0;
   logic wp = 1'b1;
   logic [1:0] regAddr = 2'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdata;
   logic [6:0] pot0Pos, pot1Pos, pot2Pos;
   logic [7:0] expMem [256];
   logic [7:0] cnt, a, d;
   logic [15:0] r;
   logic [31:0] seed = 32'h34CA366B;
   int badCount = 0;
   int checksDone = 0;
   int cycles = 0;
   always #25 clock = ~clock;
   // Open-drain wire with pull-up
   assign sdaWire = ~sdaLow & (sdaOeN | sdaOut);
   tps_bus_master u_mst (.clock(clock), .sdaWire(sdaWire),
      .sclOut(sclOut), .sdaLow(sdaLow));
   tps_slave #(.WRITE_CYCLES(WC)) u_dut (.clock(clock), .sys_rst(sysRst),
      .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .addressSelectPin(asel), .writeProtectPin(wp), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .pot0Pos(pot0Pos), .pot1Pos(pot1Pos),
      .pot2Pos(pot2Pos));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] ctrl(input logic sel, input logic rw);
      return {tps_pkg::DEV_TYPE_CODE, sel, rw};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      checksDone++;
      if (got !== exp)
      begin
         badCount++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic stopTest();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic regWrite(input logic [1:0] ad, input logic [15:0] v);
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= ad;
      regWdata <= v;
      @(posedge clock);
      regWr <= 1'b0;
   endtask
   task automatic regRead(input logic [1:0] ad, output logic [15:0] v);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge clock);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask
   // ----------------------------------------
   // Write, commit on stop, then poll
   // ----------------------------------------
   task automatic wrSeq(input logic [7:0] ad, input int n, input logic fin);
      logic ack;
      logic [7:0] x;
      logic [15:0] q [$];
      int tries;
      u_mst.start();
      u_mst.wrByte(ctrl(asel, 1'b0), ack);
      chk(ack, 1, "ctrl ack");
      u_mst.wrByte(ad, ack);
      chk(ack, 1, "addr ack");
      for (int k = 0; k < n; k++)
      begin
         x = rnd();
         u_mst.wrByte(x, ack);
         chk(ack, 1, "data ack");
         q.push_back({ad, x});
         ad = {ad[7:3], ad[2:0] + 3'h1};
      end
      if (!fin)
         return;
      u_mst.stop();
      foreach (q[i])
      begin
         if (q[i][15:8] inside {[8'hF8:8'hFA]})
         begin
            if (!wp)
               expMem[q[i][15:8]] = q[i][7:0] & 8'h7F;
         end
         else
            expMem[q[i][15:8]] = q[i][7:0];
      end
      cnt = ad;
      regRead(tps_pkg::REG_STATUS, r);
      chk(r[0], 1, "busy");
      tries = 0;
      do
      begin
         u_mst.start();
         u_mst.wrByte(ctrl(asel, 1'b0), ack);
         tries++;
      end while (!ack && tries < 20);
      chk(ack, 1, "poll ack");
      chk(tries > 1, 1, "poll nack");
   endtask
   // ----------------------------------------
   // Random or current-address read
   // ----------------------------------------
   task automatic rdSeq(input logic useAddr, input logic [7:0] ad, input int n);
      logic ack;
      logic [7:0] x;
      if (useAddr)
      begin
         u_mst.start();
         u_mst.wrByte(ctrl(asel, 1'b0), ack);
         u_mst.wrByte(ad, ack);
         chk(ack, 1, "dummy ack");
         cnt = ad;
      end
      u_mst.start();
      u_mst.wrByte(ctrl(asel, 1'b1), ack);
      chk(ack, 1, "read ctrl ack");
      for (int k = 0; k < n; k++)
      begin
         u_mst.rdByte(k < n - 1, x);
         chk(x, expMem[cnt], "read data");
         cnt++;
      end
      u_mst.stop();
      chk(sdaWire, 1, "sda released");
      regRead(tps_pkg::REG_STATUS, r);
      chk(r[15:8], cnt, "counter");
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         badCount++;
         $display("[FAIL] %0t run did not finish", $time);
         stopTest();
      end
   end
   initial
   begin
      foreach (expMem[i])
         expMem[i] = 8'h00;
      cnt = 8'h00;
      repeat (8) @(posedge clock);
      sysRst <= 1'b0;
      d = rnd();
      asel <= d[0];
      repeat (6) @(posedge clock);
      regRead(tps_pkg::REG_CTRL, r);
      chk(r, 16'h0001, "ctrl reset");
      regRead(2'h3, r);
      chk(r, 16'h0000, "unmapped");
      $display("registers done");
      for (int i = 0; i < 3; i++)
      begin
         if (i == 2)
            regWrite(tps_pkg::REG_CTRL, 16'h0000);
         u_mst.start();
         u_mst.wrByte(i == 0 ? ctrl(asel, 1'b1) ^ 8'h80
            : ctrl(asel ^ (i == 1), 1'b1), d[0]);
         chk(d[0], 0, "reject");
         u_mst.wrByte(ctrl(asel, 1'b0), d[0]);
         chk(d[0], 0, "stay idle");
         u_mst.stop();
      end
      regWrite(tps_pkg::REG_CTRL, 16'h0001);
      $display("rejects done");
      for (int i = 0; i < 2; i++)
      begin
         wp <= i[0];
         wrSeq(8'hF8, 3, 1'b1);
         rdSeq(1'b1, 8'hF8, 3);
         chk(pot0Pos, expMem[8'hF9][6:0], "pot0");
         chk(pot1Pos, expMem[8'hF8][6:0], "pot1");
         chk(pot2Pos, expMem[8'hFA][6:0], "pot2");
      end
      $display("protect done");
      wrSeq(8'hFE, 2, 1'b1);
      wrSeq(8'h00, 1, 1'b1);
      rdSeq(1'b1, 8'hFE, 3);
      rdSeq(1'b0, 8'h00, 1);
      $display("wrap done");
      d = rnd();
      a = {1'b0, d[6:3], 3'h5};
      wrSeq(a, 9, 1'b1);
      rdSeq(1'b1, {a[7:3], 3'h0}, 8);
      wrSeq(a, 1, 1'b0);
      rdSeq(1'b1, a, 1);
      $display("page done");
      repeat (3)
      begin
         d = rnd();
         a = {1'b0, d[6:0]};
         wrSeq(a, 2, 1'b1);
         rdSeq(1'b1, a, 2);
      end
      u_mst.halfP = 100;
      rdSeq(1'b1, 8'hFE, 2);
      u_mst.halfP = 25;
      asel <= ~asel;
      repeat (10) @(posedge clock);
      rdSeq(1'b1, 8'h00, 1);
      $display("random done");
      stopTest();
   end
endmodule
`default_nettype wire
